// File: dv/host_model.sv
`timescale 1ns/100ps
// ********
// host processor model: parallel cycles and serial frames
// ********
module host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n,
  output logic mode,
  output logic style,
  output logic cs_n,
  output logic cs,
  output logic a0,
  output logic rd_e,
  output logic wr_rw,
  output logic [7:0] data_in
);
  logic [7:0] host_d = 8'h00;
  logic host_en = 1'b1;
  logic [7:0] last_d = 8'h5A;
  // a released bus keeps changing, it never holds the old value
  always @(posedge clk) begin
    last_d <= data_in;
  end
  assign data_in = host_en ? host_d : (data_oe_n == 8'h00 ? data_out : ~last_d);
  // pins idle at time zero
  initial begin
    mode = 1'b1;
    style = 1'b0;
    cs_n = 1'b1;
    cs = 1'b0;
    a0 = 1'b0;
    rd_e = 1'b1;
    wr_rw = 1'b1;
  end
  // set mode, style and selects, then let them settle
  task automatic setup(input logic m, input logic s, input logic n, input logic h);
    @(negedge clk);
    mode = m;
    style = s;
    rd_e = ~s;
    wr_rw = 1'b1;
    cs_n = n;
    cs = h;
    host_en = ~m;
    host_d = 8'h00;
    repeat (6) @(negedge clk);
  endtask
  // one parallel cycle: strobe 5 clocks, data held past strobe end
  task automatic par(input logic rd, input logic sel, input logic [7:0] wd,
    output logic [7:0] rdat, output logic [7:0] oe);
    @(negedge clk);
    a0 = sel;
    host_d = wd;
    host_en = ~rd | ~mode;
    wr_rw = rd;
    rd_e = style | ~rd;
    repeat (5) @(negedge clk);
    rdat = data_in;
    oe = data_oe_n;
    rd_e = ~style;
    wr_rw = rd | ~style;
    repeat (4) @(negedge clk);
    wr_rw = 1'b1;
    host_en = ~mode;
    repeat (4) @(negedge clk);
  endtask
  // serial frame of n bits; clock rests low outside frames
  task automatic ser(input logic sel, input logic [7:0] b, input int n);
    @(negedge clk);
    a0 = sel;
    for (int i = 7; i > 7 - n; i--) begin
      host_d[7] = b[i];
      #62.5;
      host_d[6] = 1'b1;
      #62.5;
      host_d[6] = 1'b0;
    end
    @(negedge clk);
  endtask
endmodule

// File: dv/lcd_driver_host_interface_test.sv
`timescale 1ns/100ps
// ********
// self-checking bench for the host access port
// ********
module lcd_driver_host_interface_test;
  logic clk, arst_n, busy, byte_ready, overrun_clear, mem_rd_req, byte_valid, overrun;
  logic mode, style, cs_n, cs, a0, rd_e, wr_rw;
  logic [6:0] status_bits;
  logic [7:0] mem_rdata, data_out, data_oe_n, data_in, rd, oe, b;
  host_port_pkg::host_byte_t byte_out;
  int n_fail = 0;
  int samples_checked = 0;
  int npulse = 0;
  int seed;

  lcd_host_port u_lcd_host_port (.clk(clk), .arst_n(arst_n), .interface_mode_select(mode),
    .bus_style_select(style), .chip_select_active_low_n(cs_n),
    .chip_select_active_high(cs), .data_command_select(a0), .rd_e_pin(rd_e),
    .wr_rw_pin(wr_rw), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .busy(busy), .status_bits(status_bits), .mem_rdata(mem_rdata),
    .mem_rd_req(mem_rd_req), .byte_valid(byte_valid), .byte_ready(byte_ready),
    .byte_out(byte_out), .overrun(overrun), .overrun_clear(overrun_clear));
  host_model u_host_model (.clk(clk), .data_out(data_out), .data_oe_n(data_oe_n),
    .mode(mode), .style(style), .cs_n(cs_n), .cs(cs), .a0(a0), .rd_e(rd_e),
    .wr_rw(wr_rw), .data_in(data_in));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count finished data reads
  always @(negedge clk) begin
    if (mem_rd_req === 1'b1) npulse++;
  end
  // verdict and end of run
  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // compare bus-sized values
  task automatic chk_bus(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // compare bytes handed to the core
  task automatic chk_byte(input host_port_pkg::host_byte_t got,
    input host_port_pkg::host_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // expected hand-off word
  function automatic host_port_pkg::host_byte_t exp_byte(input logic sel,
    input logic [7:0] v);
    return {sel, v};
  endfunction
  // wait for a byte, check it, accept it for one cycle
  task automatic pop(input host_port_pkg::host_byte_t exp);
    int k;
    k = 0;
    @(negedge clk);
    while (byte_valid !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk_byte(byte_out, exp);
    byte_ready = 1'b1;
    @(negedge clk);
    byte_ready = 1'b0;
  endtask
  // watchdog
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
  // main sequence
  initial begin
    seed = 32'h5413846a;
    arst_n = 1'b0;
    busy = 1'b0;
    byte_ready = 1'b0;
    overrun_clear = 1'b0;
    status_bits = 7'h00;
    mem_rdata = 8'h00;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    chk_bus(data_oe_n, 8'hFF);
    // parallel writes, status and data reads in both bus styles
    for (int s = 0; s < 2; s++) begin
      u_host_model.setup(1'b1, s[0], 1'b1, 1'b0);
      u_host_model.setup(1'b1, s[0], 1'b0, 1'b1);
      for (int k = 0; k < 4; k++) begin
        b = 8'($random(seed));
        u_host_model.par(1'b0, k[0], b, rd, oe);
        pop(exp_byte(k[0], b));
      end
      status_bits = 7'($random(seed));
      busy = s[0];
      u_host_model.par(1'b1, 1'b0, 8'h00, rd, oe);
      chk_bus(rd, {busy, status_bits});
      chk_bus(oe, 8'h00);
      u_host_model.par(1'b0, 1'b1, 8'h3C, rd, oe);
      if (s == 0) pop(exp_byte(1'b1, 8'h3C));
      else chk_bus({7'h00, byte_valid}, 8'h00);
      busy = 1'b0;
      b = 8'($random(seed));
      mem_rdata = b;
      npulse = 0;
      u_host_model.par(1'b1, 1'b1, 8'h00, rd, oe);
      mem_rdata = ~b;
      u_host_model.par(1'b1, 1'b1, 8'h00, rd, oe);
      chk_bus(rd, b);
      chk_bus(npulse[7:0], 8'h02);
    end
    // deselected by either select: bus floats, strobes ignored
    for (int s = 0; s < 2; s++) begin
      u_host_model.setup(1'b1, 1'b0, s[0], s[0]);
      u_host_model.par(1'b1, 1'b0, 8'h00, rd, oe);
      chk_bus(oe, 8'hFF);
      u_host_model.par(1'b0, 1'b1, 8'hA5, rd, oe);
      chk_bus({7'h00, byte_valid}, 8'h00);
    end
    // serial frames, a frame cut by deselect, a read attempt
    u_host_model.setup(1'b0, 1'b0, 1'b1, 1'b0);
    u_host_model.setup(1'b0, 1'b0, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      u_host_model.ser(b[0], b, 8);
      pop(exp_byte(b[0], b));
    end
    u_host_model.ser(1'b1, 8'hFF, 5);
    u_host_model.setup(1'b0, 1'b0, 1'b1, 1'b0);
    u_host_model.setup(1'b0, 1'b0, 1'b0, 1'b1);
    u_host_model.ser(1'b0, 8'h96, 8);
    pop(exp_byte(1'b0, 8'h96));
    u_host_model.par(1'b1, 1'b0, 8'h00, rd, oe);
    chk_bus(oe, 8'hFF);
    // stalled receiver: three bytes wait, a fourth overruns
    for (int k = 0; k < 3; k++) begin
      u_host_model.ser(1'b1, 8'h10 + k[7:0], 8);
    end
    for (int k = 0; k < 3; k++) begin
      pop(exp_byte(1'b1, 8'h10 + k[7:0]));
    end
    chk_bus({7'h00, overrun}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      u_host_model.ser(1'b0, 8'h20 + k[7:0], 8);
    end
    chk_bus({7'h00, overrun}, 8'h01);
    overrun_clear = 1'b1;
    byte_ready = 1'b1;
    repeat (10) @(negedge clk);
    overrun_clear = 1'b0;
    byte_ready = 1'b0;
    chk_bus({6'h00, overrun, byte_valid}, 8'h00);
    end_of_test();
  end
endmodule

// File: hdl/byte_skid_buf.sv
`timescale 1ns/100ps
// ************************************************************
// two-entry buffer, outputs straight from flip-flops
// ************************************************************
module byte_skid_buf #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic spare_valid_ff;
  logic [W-1:0] spare_ff;
  logic push;
  logic pop;

  assign in_ready = !spare_valid_ff;
  assign push = in_valid && !spare_valid_ff;
  assign pop = out_valid && out_ready;

  // head entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (!out_valid || pop) begin
      out_valid <= spare_valid_ff || push;
      out_data <= spare_valid_ff ? spare_ff : in_data;
    end
  end

  // spare entry catches a word while the head is stalled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spare_valid_ff <= 1'b0;
      spare_ff <= '0;
    end else if (out_valid && !pop && push) begin
      spare_valid_ff <= 1'b1;
      spare_ff <= in_data;
    end else if (pop) begin
      spare_valid_ff <= 1'b0;
    end
  end

endmodule

// File: hdl/host_port_pkg.sv
package host_port_pkg;

  // ************************************************************
  // widths and bit positions
  // ************************************************************
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam int PIN_W = 15;
  localparam int SI_BIT = 7;
  localparam int SCL_BIT = 6;
  localparam int BUSY_BIT = 7;

  // ************************************************************
  // constant values
  // ************************************************************
  localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] OE_N_OFF = 8'hFF;
  localparam logic [BYTE_W-1:0] OE_N_ON = 8'h00;

  // access type: {data_command_select, read}
  typedef enum logic [1:0] {
    ACC_CMD_WR = 2'b00,
    ACC_STATUS_RD = 2'b01,
    ACC_DATA_WR = 2'b10,
    ACC_DATA_RD = 2'b11
  } acc_t;

  // byte handed to the core
  typedef struct packed {
    logic is_data;
    logic [BYTE_W-1:0] value;
  } host_byte_t;

  localparam host_byte_t HOST_BYTE_RST = '{is_data: 1'b0, value: 8'h00};

  // host pins after synchronisation
  typedef struct packed {
    logic par_mode;
    logic bus_style_select;
    logic chip_select_active_low;
    logic chip_select_active_high;
    logic data_command_select;
    logic rd_e;
    logic wr_rw;
    logic [BYTE_W-1:0] data;
  } host_pins_t;

endpackage

// File: hdl/lcd_host_port.sv
`timescale 1ns/100ps
// ************************************************************
// host access port: parallel 68/80 style bus or serial link
// ************************************************************
module lcd_host_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic interface_mode_select,
  input wire logic bus_style_select,
  input wire logic chip_select_active_low_n,
  input wire logic chip_select_active_high,
  input wire logic data_command_select,
  input wire logic rd_e_pin,
  input wire logic wr_rw_pin,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe_n,
  input wire logic busy,
  input wire logic [6:0] status_bits,
  input wire logic [7:0] mem_rdata,
  output logic mem_rd_req,
  output logic byte_valid,
  input wire logic byte_ready,
  output host_port_pkg::host_byte_t byte_out,
  output logic overrun,
  input wire logic overrun_clear
);

  // ************************************************************
  // pin synchronisation
  // ************************************************************
  host_port_pkg::host_pins_t pins_raw;
  host_port_pkg::host_pins_t pins_s;

  assign pins_raw = '{par_mode: interface_mode_select,
                      bus_style_select: bus_style_select,
                      chip_select_active_low: chip_select_active_low_n,
                      chip_select_active_high: chip_select_active_high,
                      data_command_select: data_command_select,
                      rd_e: rd_e_pin,
                      wr_rw: wr_rw_pin,
                      data: data_in};

  // every pin passes two flops; serial clock too
  pin_sync #(.W(host_port_pkg::PIN_W)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  // ************************************************************
  // select and strobe decode
  // ************************************************************
  logic sel;
  logic par_on;
  logic ser_on;
  logic rd_raw;
  logic wr_raw;
  logic rd_act_ff;
  logic wr_act_ff;
  logic rd_end;
  logic wr_end;
  logic scl_prev_ff;
  logic scl_rise;
  host_port_pkg::acc_t acc;

  // both selects must be active; the mode pin is expected to stay fixed
  assign sel = !pins_s.chip_select_active_low && pins_s.chip_select_active_high;
  assign par_on = sel && pins_s.par_mode;
  assign ser_on = sel && !pins_s.par_mode;

  // high style pin: enable plus read/write; low: active-low strobes
  always_comb begin
    if (pins_s.bus_style_select) begin
      rd_raw = pins_s.rd_e && pins_s.wr_rw;
      wr_raw = pins_s.rd_e && !pins_s.wr_rw;
    end else begin
      rd_raw = !pins_s.rd_e && pins_s.wr_rw;
      wr_raw = !pins_s.wr_rw && pins_s.rd_e;
    end
  end

  // strobe ends and serial clock rises, found in the same cycle the synchronised pins change
  assign acc = host_port_pkg::acc_t'({pins_s.data_command_select, rd_raw});
  assign rd_end = par_on && rd_act_ff && !rd_raw;
  assign wr_end = par_on && wr_act_ff && !wr_raw;
  assign scl_rise = pins_s.data[host_port_pkg::SCL_BIT] && !scl_prev_ff;

  // strobe and serial clock history for edge finding
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_act_ff <= 1'b0;
      wr_act_ff <= 1'b0;
      scl_prev_ff <= 1'b0;
    end else begin
      rd_act_ff <= par_on && rd_raw;
      wr_act_ff <= par_on && wr_raw;
      scl_prev_ff <= pins_s.data[host_port_pkg::SCL_BIT];
    end
  end

  // ************************************************************
  // parallel read path and bus holder
  // ************************************************************
  logic [7:0] holder_ff;
  logic [7:0] nxt_data_out;

  // status carries busy on bit 7; data reads come from the holder
  always_comb begin
    case (acc)
      host_port_pkg::ACC_STATUS_RD: nxt_data_out = {busy, status_bits};
      host_port_pkg::ACC_DATA_RD: nxt_data_out = holder_ff;
      host_port_pkg::ACC_CMD_WR: nxt_data_out = data_out;
      host_port_pkg::ACC_DATA_WR: nxt_data_out = data_out;
      default: nxt_data_out = data_out;
    endcase
  end

  // drive the bus only during a parallel read while selected
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= host_port_pkg::BYTE_RST;
      data_oe_n <= host_port_pkg::OE_N_OFF;
    end else begin
      data_out <= nxt_data_out;
      if (par_on && rd_raw) begin
        data_oe_n <= host_port_pkg::OE_N_ON;
      end else begin
        data_oe_n <= host_port_pkg::OE_N_OFF;
      end
    end
  end

  // a finished data read while not busy reloads the holder, so data comes one read late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      holder_ff <= host_port_pkg::BYTE_RST;
      mem_rd_req <= 1'b0;
    end else begin
      mem_rd_req <= 1'b0;
      if (rd_end && pins_s.data_command_select && !busy) begin
        holder_ff <= mem_rdata;
        mem_rd_req <= 1'b1;
      end
    end
  end

  // ************************************************************
  // serial receiver
  // ************************************************************
  logic [7:0] shift_ff;
  logic [host_port_pkg::CNT_W-1:0] cnt_ff;
  logic [7:0] nxt_shift;
  logic ser_byte_done;

  assign nxt_shift = {shift_ff[6:0], pins_s.data[host_port_pkg::SI_BIT]};
  assign ser_byte_done = ser_on && scl_rise && (cnt_ff == host_port_pkg::CNT_LAST);

  // shift msb first; deselect returns to initial state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= host_port_pkg::BYTE_RST;
      cnt_ff <= host_port_pkg::CNT_RST;
    end else if (!ser_on) begin
      shift_ff <= host_port_pkg::BYTE_RST;
      cnt_ff <= host_port_pkg::CNT_RST;
    end else if (scl_rise) begin
      shift_ff <= nxt_shift;
      cnt_ff <= cnt_ff + host_port_pkg::CNT_ONE;
    end
  end

  // ************************************************************
  // hand-off register into the buffer
  // ************************************************************
  logic push_valid_ff;
  host_port_pkg::host_byte_t push_byte_ff;
  logic buf_in_ready;
  logic new_byte;
  host_port_pkg::host_byte_t nxt_push_byte;

  // busy refuses a parallel write; a serial byte is never refused
  assign new_byte = ser_byte_done || (wr_end && !busy);
  // the host still holds write data and select when the strobe end is seen
  assign nxt_push_byte = '{is_data: pins_s.data_command_select,
                           value: ser_byte_done ? nxt_shift : pins_s.data};

  // hold the byte until the buffer takes it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      push_valid_ff <= 1'b0;
      push_byte_ff <= host_port_pkg::HOST_BYTE_RST;
    end else if (new_byte) begin
      push_valid_ff <= 1'b1;
      push_byte_ff <= nxt_push_byte;
    end else if (buf_in_ready) begin
      push_valid_ff <= 1'b0;
    end
  end

  // sticky when a byte arrives while the previous one still waits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun <= 1'b0;
    end else if (new_byte && push_valid_ff && !buf_in_ready) begin
      overrun <= 1'b1;
    end else if (overrun_clear) begin
      overrun <= 1'b0;
    end
  end

  byte_skid_buf #(.W($bits(host_port_pkg::host_byte_t))) u_buf (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_valid_ff),
    .in_ready(buf_in_ready),
    .in_data(push_byte_ff),
    .out_valid(byte_valid),
    .out_ready(byte_ready),
    .out_data(byte_out)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // bus drive follows select, mode and the read strobe
  a_deselect_float: assert property (!sel |=> data_oe_n == host_port_pkg::OE_N_OFF)
    else $error("bus driven while deselected");
  a_serial_no_drive: assert property (!pins_s.par_mode |=> &data_oe_n)
    else $error("bus driven in serial mode");
  a_read_drives_bus: assert property (par_on && rd_raw |=> data_oe_n == 8'h00)
    else $error("read strobe did not drive the bus");
  a_write_no_drive: assert property (par_on && wr_raw |=> &data_oe_n)
    else $error("bus driven during a write strobe");

  // serial receiver state
  a_deselect_clears: assert property (!ser_on |=> cnt_ff == 3'h0 && shift_ff == 8'h00)
    else $error("serial state kept while deselected");
  a_count_steps: assert property (ser_on && scl_rise |=> cnt_ff == 3'($past(cnt_ff) + 3'h1))
    else $error("bit counter did not advance");
  a_shift_holds: assert property (ser_on && !scl_rise |=>
      $stable(shift_ff) && $stable(cnt_ff))
    else $error("serial state moved without a clock edge");
  a_eighth_edge_byte: assert property (ser_byte_done |=>
      push_valid_ff && push_byte_ff.value == $past(nxt_shift))
    else $error("serial byte not handed on");
  a_serial_kind: assert property (ser_byte_done |=>
      push_byte_ff.is_data == $past(pins_s.data_command_select))
    else $error("serial data or command misjudged");
  a_ser_no_fetch: assert property (ser_on |=> !mem_rd_req)
    else $error("memory read requested in serial mode");

  // parallel status, data and write paths
  a_status_busy: assert property (par_on && acc == host_port_pkg::ACC_STATUS_RD |=>
      data_out[7] == $past(busy))
    else $error("busy not on bit 7");
  a_status_low_bits: assert property (par_on && acc == host_port_pkg::ACC_STATUS_RD |=>
      data_out[6:0] == $past(status_bits))
    else $error("status bits not on the bus");
  a_data_from_holder: assert property (par_on && acc == host_port_pkg::ACC_DATA_RD |=>
      data_out == $past(holder_ff))
    else $error("data read not taken from the holder");
  a_busy_blocks_write: assert property (wr_end && busy && !ser_byte_done &&
      !push_valid_ff |=> !push_valid_ff)
    else $error("write accepted while busy");
  a_busy_blocks_read: assert property (rd_end && busy |=> !mem_rd_req)
    else $error("data read accepted while busy");
  a_status_no_fetch: assert property (rd_end && !pins_s.data_command_select |=> !mem_rd_req)
    else $error("status read advanced the memory");
  a_write_taken: assert property (wr_end && !busy |=>
      push_valid_ff && push_byte_ff.value == $past(pins_s.data))
    else $error("parallel write lost");
  a_write_kind: assert property (wr_end && !busy |=>
      push_byte_ff.is_data == $past(pins_s.data_command_select))
    else $error("write data or command misjudged");
  a_holder_late: assert property (rd_end && pins_s.data_command_select && !busy |=>
      holder_ff == $past(mem_rdata) && mem_rd_req)
    else $error("holder not reloaded");
  a_deselect_no_push: assert property (!sel && !push_valid_ff |=> !push_valid_ff)
    else $error("byte taken while deselected");

  // hand-off and buffer
  a_stall_holds: assert property (byte_valid && !byte_ready |=>
      byte_valid && $stable(byte_out))
    else $error("stalled byte changed or dropped");
  a_overrun_sets: assert property (new_byte && push_valid_ff && !buf_in_ready |=>
      overrun)
    else $error("overrun not flagged");
  a_overrun_sticky: assert property (overrun && !overrun_clear |=> overrun)
    else $error("overrun dropped without a clear");

  // ************************************************************
  // cover points
  // ************************************************************
  c_serial_byte: cover property (ser_byte_done);
  c_parallel_write: cover property (wr_end && !busy);
  c_data_read: cover property (mem_rd_req);
  c_status_busy: cover property (par_on && rd_raw && busy);
  c_overrun: cover property (new_byte && push_valid_ff && !buf_in_ready);

endmodule

// File: hdl/pin_sync.sv
`timescale 1ns/100ps
// ************************************************************
// two flip-flop synchroniser for asynchronous pins
// ************************************************************
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // first stage read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule
